// >>> design/lp_ctrl.sv
`include "lp_ctrl_params.svh"

module lp_ctrl
	import lp_ctrl_pkg::*;
#(
	parameter int STAB_CYCLES = `STAB_CYCLES_DEFAULT
) (
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire lp_ctrl_pkg::lp_req_type   req,
	input  wire lp_ctrl_pkg::irq_in_type   irq,
	input  wire logic                      global_irq_enable,
	input  wire logic                      wdog_active,
	input  wire logic                      osc_sel_in,
	output logic                           core_halt,
	output logic                           osc_run,
	output logic                           periph_clk_en,
	output logic                           osc_sel,
	output logic                           insn_skip,
	output logic                           irq_allowed,
	output logic                           nmi_allowed,
	output lp_ctrl_pkg::wake_out_type      wake_out,
	output lp_ctrl_pkg::lp_state_type      state
);
	import lp_ctrl_pkg::*;

	//--------------------------------------------------------------
	// Request qualification
	//--------------------------------------------------------------
	logic                        maskable_irq;
	logic                        wake_wait;
	logic                        wake_stop;
	logic                        enter_wait;
	logic                        enter_stop;
	logic                        stab_done;
	logic [`STAB_CNT_WIDTH-1:0]  stab_cnt;
	ctx_type                     ctx;
	logic                        wake_nmi;
	lp_state_type                next_state;

	// Maskable sources gated by the global enable; NMI is never masked
	// for servicing, only for waking
	assign maskable_irq = global_irq_enable &
		(irq.periph_irq | irq.ext_irq);
	assign irq_allowed  = global_irq_enable;
	assign nmi_allowed  = 1'b1;

	// A pending enabled request makes the instruction a no-op
	assign insn_skip = (req.wait_done | req.stop_done) &
		irq.pending;

	// Stop becomes wait while the watchdog runs
	assign enter_stop = req.stop_done & ~irq.pending &
		~wdog_active;
	assign enter_wait = ~irq.pending & (req.wait_done |
		(req.stop_done & wdog_active));

	// Wake sources; with global enable low nothing but reset wakes
	assign wake_wait = global_irq_enable &
		(irq.periph_irq | irq.ext_irq | irq.nmi);
	// Oscillator is stopped, so only the external lines can wake
	assign wake_stop = global_irq_enable &
		(irq.ext_irq | irq.nmi);

	assign stab_done = (stab_cnt == `STAB_CNT_ONE);

	//--------------------------------------------------------------
	// State machine
	//--------------------------------------------------------------
	// Reset from pin or watchdog comes in on sys_rst, which drops us
	// back to run from any state so the normal reset sequence follows
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (enter_stop) begin
					next_state = ST_STOP;
				end else if (enter_wait) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wake_wait) begin
					next_state = ST_RUN;
				end
			end
			ST_STOP: begin
				if (wake_stop) begin
					next_state = ST_STAB;
				end
			end
			ST_STAB: begin
				if (stab_done) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// State register; asynchronous reset covers both reset sources
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	//--------------------------------------------------------------
	// Stabilisation counter
	//--------------------------------------------------------------
	// Loaded on the stop wake and counted on the restarted oscillator
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stab_cnt <= `STAB_CNT_ZERO;
		end else if (state == ST_STOP && wake_stop) begin
			stab_cnt <= STAB_CYCLES[`STAB_CNT_WIDTH-1:0];
		end else if (state == ST_STAB && stab_cnt != `STAB_CNT_ZERO) begin
			stab_cnt <= stab_cnt - `STAB_CNT_ONE;
		end
	end

	//--------------------------------------------------------------
	// Context capture and wake cause
	//--------------------------------------------------------------
	// Context is latched at entry since the core is frozen meanwhile
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctx <= CTX_MAIN;
		end else if (state == ST_RUN && (enter_wait || enter_stop)) begin
			ctx <= req.ctx;
		end
	end

	// Remember whether the NMI was the waking source
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wake_nmi <= 1'b0;
		end else if ((state == ST_WAIT && wake_wait) ||
			(state == ST_STOP && wake_stop)) begin
			wake_nmi <= irq.nmi;
		end
	end

	//--------------------------------------------------------------
	// Wake report to the core
	//--------------------------------------------------------------
	// One-cycle pulse when the core restarts; action by prior context
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wake_out <= '0;
		end else begin
			wake_out.wake     <= 1'b0;
			wake_out.action   <= RES_NONE;
			wake_out.from_nmi <= 1'b0;
			if ((state == ST_WAIT && wake_wait) ||
				(state == ST_STAB && stab_done)) begin
				wake_out.wake     <= 1'b1;
				wake_out.from_nmi <= (state == ST_WAIT) ? irq.nmi
					: wake_nmi;
				case (ctx)
					CTX_NMI: begin
						wake_out.action <= RES_NEXT_INSN;
					end
					CTX_IRQ: begin
						if ((state == ST_WAIT) ? irq.nmi : wake_nmi) begin
							wake_out.action <= RES_NMI_FIRST;
						end else begin
							wake_out.action <= RES_NEXT_INSN;
						end
					end
					default: begin
						wake_out.action <= RES_SERVICE;
					end
				endcase
			end
		end
	end

	//--------------------------------------------------------------
	// Clock and core controls
	//--------------------------------------------------------------
	// Core frozen in any low-power or stabilising state; storage is
	// untouched because only the fetch is held
	assign core_halt     = (state != ST_RUN);
	// Oscillator stops only in stop; it runs again while stabilising
	assign osc_run       = (state != ST_STOP);
	assign periph_clk_en = (state == ST_RUN) ||
		(state == ST_WAIT);

	// Oscillator selection follows software only while running, so
	// no wake-up path ever alters it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			osc_sel <= 1'b0;
		end else if (state == ST_RUN) begin
			osc_sel <= osc_sel_in;
		end
	end

endmodule

// >>> design/lp_ctrl_params.svh
`ifndef LP_CTRL_PARAMS_SVH
`define LP_CTRL_PARAMS_SVH

// Oscillator stabilisation delay after a stop exit, in oscillator cycles
`define STAB_CYCLES_DEFAULT 16'h0100
`define STAB_CNT_WIDTH      16
`define STAB_CNT_ONE        16'h0001
`define STAB_CNT_ZERO       16'h0000

`endif

// >>> design/lp_ctrl_pkg.sv
package lp_ctrl_pkg;

	// Execution context of the core when the low-power instruction ran
	typedef enum logic [1:0] {
		CTX_MAIN = 2'b00,
		CTX_IRQ  = 2'b01,
		CTX_NMI  = 2'b10
	} ctx_type;

	// Resume action handed back to the core
	typedef enum logic [1:0] {
		RES_NONE      = 2'b00,
		RES_SERVICE   = 2'b01,
		RES_NEXT_INSN = 2'b10,
		RES_NMI_FIRST = 2'b11
	} resume_type;

	// Controller states
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_WAIT = 2'b01,
		ST_STOP = 2'b10,
		ST_STAB = 2'b11
	} lp_state_type;

	// Low-power request from the instruction decoder
	typedef struct packed {
		logic    wait_done;
		logic    stop_done;
		ctx_type ctx;
	} lp_req_type;

	// Interrupt request lines seen by the controller
	typedef struct packed {
		logic periph_irq;
		logic ext_irq;
		logic nmi;
		logic pending;
	} irq_in_type;

	// Wake report to the core
	typedef struct packed {
		logic       wake;
		resume_type action;
		logic       from_nmi;
	} wake_out_type;

endpackage

// >>> tb/core_model.sv
module core_model
	import lp_ctrl_pkg::*;
(
	input wire logic	clk,
	output lp_ctrl_pkg::lp_req_type	req,
	output lp_ctrl_pkg::irq_in_type	irq
);
	timeunit 1ns;
	timeprecision 1ns;

	// Quiet core and interrupt lines until the bench asks
	initial begin
		req = '0;
		irq = '0;
	end

	// Values land just after an edge; a pulse lasts one cycle because
	// the caller drives the next value one edge later
	task automatic drive(input lp_req_type r, input irq_in_type i);
		@(posedge clk);
		#1;
		req = r;
		irq = i;
	endtask
endmodule

// >>> tb/lp_ctrl_assertions.sv
module lp_ctrl_chk
	import lp_ctrl_pkg::*;
#(parameter int STAB_CYCLES = 256) (
	input wire logic	clk,
	input wire logic	sys_rst,
	input wire lp_ctrl_pkg::lp_req_type	req,
	input wire lp_ctrl_pkg::irq_in_type	irq,
	input wire logic	global_irq_enable,
	input wire logic	wdog_active,
	input wire logic	core_halt,
	input wire logic	osc_run,
	input wire logic	periph_clk_en,
	input wire logic	osc_sel,
	input wire logic	insn_skip,
	input wire lp_ctrl_pkg::wake_out_type	wake_out,
	input wire lp_ctrl_pkg::lp_state_type	state
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [15:0]	stab_cnt;

	// Cycles spent in STAB, so the stop-exit delay is timed exactly
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			stab_cnt <= 16'h0000;
		else
			stab_cnt <= (state == ST_STAB) ? stab_cnt + 16'h0001 : 16'h0000;
	end

	wait_entry_a: assert property (
		state == ST_RUN && req.wait_done && !irq.pending |=> state == ST_WAIT)
		else $error("no wait entry");
	stop_entry_a: assert property (
		state == ST_RUN && req.stop_done && !irq.pending
		|=> state == ($past(wdog_active) ? ST_WAIT : ST_STOP))
		else $error("bad stop entry");
	insn_skip_a: assert property (
		state == ST_RUN && irq.pending && (req.wait_done || req.stop_done)
		|-> insn_skip ##1 state == ST_RUN) else $error("request not skipped");
	wait_clock_a: assert property (
		state == ST_WAIT |-> core_halt && osc_run && periph_clk_en)
		else $error("wait clocks wrong");
	stop_osc_a: assert property (
		state == ST_STOP |-> core_halt && !osc_run) else $error("stop osc on");
	wait_wake_a: assert property (
		state == ST_WAIT && global_irq_enable &&
		(irq.periph_irq || irq.ext_irq || irq.nmi)
		|=> state == ST_RUN && wake_out.wake) else $error("wait wake wrong");
	stop_hold_a: assert property (
		state == ST_STOP && !(global_irq_enable && (irq.ext_irq || irq.nmi))
		|=> state == ST_STOP) else $error("stop left early");
	stab_len_a: assert property (
		state == ST_RUN && $past(state) == ST_STAB
		|-> stab_cnt == 16'(STAB_CYCLES) && wake_out.wake)
		else $error("stabilisation length wrong");
	osc_keep_a: assert property (
		state != ST_RUN |=> $stable(osc_sel)) else $error("osc select moved");
endmodule

bind lp_ctrl lp_ctrl_chk #(.STAB_CYCLES(STAB_CYCLES)) chk (.*);

// >>> tb/tb_top.sv
module tb_top
	import lp_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic	clk = 0, sys_rst = 1, gie = 0, wd = 0, osel = 0;
	logic	halt, orun, pclk, osc_sel, skip, ia, na;
	lp_req_type	req;
	irq_in_type	irq;
	wake_out_type	wo;
	lp_state_type	st;
	int	err_count = 0, num_checks = 0;
	logic [7:0]	rnd = 8'h20;

	core_model core (.clk(clk), .req(req), .irq(irq));
	lp_ctrl #(.STAB_CYCLES(4)) dut (.clk(clk), .sys_rst(sys_rst), .req(req),
		.irq(irq), .global_irq_enable(gie), .wdog_active(wd),
		.osc_sel_in(osel), .core_halt(halt), .osc_run(orun),
		.periph_clk_en(pclk), .osc_sel(osc_sel), .insn_skip(skip),
		.irq_allowed(ia), .nmi_allowed(na), .wake_out(wo), .state(st));

	// Bench clock, 50 ns period
	initial forever #25 clk = ~clk;

	// Cuts a hang short; the run needs well under 1000 cycles
	initial begin
		#100000;
		err_count++;
		give_verdict();
	end

	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic chk(input string nm, input logic [7:0] seen, want);
		num_checks++;
		if (seen !== want) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, want, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One sleep and wake; m: 0 wait, 1 stop, 2 stop with watchdog on
	task automatic lp_cycle(input int m, input int c, input int s);
		lp_req_type	r;
		irq_in_type	src;
		logic	keep;
		int	ex, ea, n;
		src = 4'h8 >> s;
		r = {m == 0, m != 0, 2'(c)};
		ex = (m == 1) ? 2 : 1;
		ea = (c == 0) ? 1 : (c == 1 && s == 2) ? 3 : 2;
		wd = (m == 2);
		rnd = lfsr(rnd);
		osel = rnd[0];
		keep = rnd[0];
		core.drive(r, '0);
		core.drive('0, src);
		chk("state", st, 8'(ex));
		chk("halt", halt, 1'b1);
		chk("periph_clk", pclk, m != 1);
		chk("osc_run", orun, m != 1);
		chk("irq_masked", ia, 1'b0);
		osel = ~keep;
		repeat (3) @(posedge clk);
		#1 chk("no_wake", st, 8'(ex));
		gie = 1;
		chk("irq_allowed", ia, 1'b1);
		chk("nmi_allowed", na, 1'b1);
		if (m == 1 && s == 0) begin
			repeat (3) @(posedge clk);
			#1 chk("periph_stop", st, 8'(ex));
			core.drive('0, 4'h4);
		end
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (wo.wake !== 1'b1 && n < 20);
		chk("delay", 8'(n), (m == 1) ? 8'h05 : 8'h01);
		chk("from_nmi", wo.from_nmi, s == 2);
		chk("action", wo.action, 8'(ea));
		chk("osc_sel", osc_sel, keep);
		core.drive('0, '0);
		gie = 0;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		#1 sys_rst = 0;
		core.drive(4'h8, 4'h1);
		#1 chk("skip", skip, 1'b1);
		core.drive('0, '0);
		chk("skip_state", st, 8'h00);
		for (int m = 0; m < 3; m++)
			for (int c = 0; c < 3; c++)
				for (int s = 0; s < 3; s++)
					lp_cycle(m, c, s);
		wd = 0;
		for (int m = 0; m < 2; m++) begin
			core.drive({m == 0, m == 1, 2'b00}, '0);
			core.drive('0, '0);
			sys_rst = 1;
			#5 chk("reset_exit", st, 8'h00);
			@(posedge clk);
			#1 sys_rst = 0;
		end
		give_verdict();
	end
endmodule
